// *** rtl/ipc_core.sv ***
// Interrupt priority control: per-source 3-bit priorities, pending and
// enable flags, nesting, CPU level, timed disable, traps, vector status.
// Assumes a classic Wishbone master and a core that pulses take/return.
// The core samples cpu_irq_o and cpu_vector_o combinationally. It answers
// with one take pulse per accepted request. Every handler ends with one
// return pulse. Requests from peripherals and traps arrive synchronous to
// clk_i. Each is one cycle wide or held high; holding only re-sets the
// pending flag.
//
// Limitations a user should know:
// - The save stack holds DEPTH levels. A take beyond that is ignored, so
//   the core must not nest deeper than DEPTH handlers.
// - Writes need byte lanes 0 and 1. A narrower write is acknowledged but
//   changes nothing, which keeps the 16-bit registers whole.
// - The pending vector is shown even while the request is held back by
//   the CPU level, so software can see what is waiting.
`timescale 1ns/100ps
module ipc_core
  import ipc_pkg::*;
#(
  parameter int          TIMED_IRQ_DISABLE_CYCLES = IPC_TIMED_IRQ_DISABLE_CYCLES,
  parameter bit          HAS_CAN     = 1'b1,
  parameter int          DEPTH       = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  input  wire logic [IPC_NSRC-1:0]   src_req_i,
  input  wire logic [IPC_NTRAP-1:0]  trap_req_i,
  input  wire logic                  take_i,
  input  wire logic                  return_from_irq_i,
  input  wire logic                  timed_irq_disable_i,
  output logic                       cpu_irq_o,
  output logic      [6:0]            cpu_vector_o,
  output logic      [3:0]            cpu_level_now_o,
  output logic                       irq_o
);

  logic [2:0]          prio_r [IPC_NSRC];
  logic [IPC_NSRC-1:0] pend_r;
  logic [IPC_NSRC-1:0] en_r;
  logic                nest_dis_r;
  logic [IPC_NTRAP-1:0] trap_flag_r;
  logic [3:0]          lvl_r;
  logic [7:0]          status_low_byte_r;
  logic [3:0]          stk_lvl_r [DEPTH];
  logic [7:0]          stk_sr_r  [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] sp_r;
  logic [15:0]         timed_irq_disable_cnt_r;
  logic [IPC_NEV-1:0]  ev_stat_r;
  logic [IPC_NEV-1:0]  ev_mask_r;
  logic                ack_r;

  // Bus decode: single-cycle ack, registered.
  // A write lands at the edge that takes the request, one edge before the
  // master sees ack. Read data is registered at that same edge, so it
  // stands beside ack. The !ack_r term stops a held strobe from being
  // taken again in the ack cycle. A master may keep stb high for the next request; it is taken one cycle after ack.
  logic wr_en;
  logic rd_en;
  assign rd_en = cyc_i && stb_i && !ack_r && !we_i;
  assign wr_en = cyc_i && stb_i && !ack_r && we_i && sel_i[0] && sel_i[1];
  assign ack_o = ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i && stb_i && !ack_r;
    end
  end

  // Register layout: which register and bit position holds each source.
  // Both the write path and the read path use these functions. The map is
  // then kept in one place, and a field cannot be written at one position
  // and read back at another.
  function automatic logic [7:0] src_ofs(input int s);
    case (s)
      IPC_SRC_X3, IPC_SRC_X4, IPC_SRC_PP:  src_ofs = (s == IPC_SRC_X3) ? IPC_OFS_PRIO9 :
                                                      IPC_OFS_PRIO11;
      IPC_SRC_X5, IPC_SRC_CAL:             src_ofs = IPC_OFS_PRIO15;
      IPC_SRC_S1E, IPC_SRC_S2E, IPC_SRC_CRC: src_ofs = IPC_OFS_PRIO16;
      default:                             src_ofs = IPC_OFS_PRIO17;
    endcase
  endfunction : src_ofs

  function automatic int src_pos(input int s);
    case (s)
      IPC_SRC_X3:    src_pos = IPC_POS_LO;
      IPC_SRC_X4:    src_pos = IPC_POS_HI;
      IPC_SRC_PP:    src_pos = IPC_POS_MID;
      IPC_SRC_X5:    src_pos = IPC_POS_MID;
      IPC_SRC_CAL:   src_pos = IPC_POS_HI;
      IPC_SRC_S1E:   src_pos = IPC_POS_MID;
      IPC_SRC_S2E:   src_pos = IPC_POS_HI;
      IPC_SRC_CRC:   src_pos = IPC_POS_TOP;
      IPC_SRC_X6:    src_pos = IPC_POS_LO;
      IPC_SRC_X7:    src_pos = IPC_POS_MID;
      default:       src_pos = IPC_POS_HI;
    endcase
  endfunction : src_pos

  // Effective level of a source: zero when off or absent.
  // A source counts only when it is pending and enabled. Its field must be
  // nonzero, and it must exist on this variant. Folding all of that into a
  // level of zero lets the arbiter treat every source the same way.
  logic [2:0] eff_lvl [IPC_NSRC];
  genvar g;
  generate
    for (g = 0; g < IPC_NSRC; g++) begin : g_src
      always_comb begin
        if (g == IPC_SRC_CANTX && !HAS_CAN) begin
          eff_lvl[g] = IPC_PRIO_OFF;
        end else if (pend_r[g] && en_r[g]) begin
          eff_lvl[g] = prio_r[g];
        end else begin
          eff_lvl[g] = IPC_PRIO_OFF;
        end
      end

      // Priority field storage; only the three field bits exist
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          prio_r[g] <= IPC_PRIO_RST;
        end else if (wr_en && adr_i == src_ofs(g)) begin
          prio_r[g] <= dat_i[src_pos(g) +: 3];
        end
      end
    end
  endgenerate

  // Arbitration: highest user level, then lowest index; traps above all.
  // The user loop runs from the top index down with >=. A tie therefore
  // goes to the lowest index, which also has the lowest vector. The trap
  // loop runs after it and overrides any user winner. Its lowest set trap
  // wins; traps are never compared against the CPU level.
  logic [3:0] best_lvl;
  logic [6:0] best_vec;
  logic       best_trap;
  logic [$clog2(IPC_NSRC)-1:0] best_idx;
  always_comb begin
    best_lvl  = 4'h0;
    best_vec  = 7'h00;
    best_trap = 1'b0;
    best_idx  = '0;
    for (int s = IPC_NSRC - 1; s >= 0; s--) begin
      if ({1'b0, eff_lvl[s]} != 4'h0 && {1'b0, eff_lvl[s]} >= best_lvl) begin
        best_lvl = {1'b0, eff_lvl[s]};
        best_vec = IPC_VEC_BASE + 7'(s);
        best_idx = ($clog2(IPC_NSRC))'(s);
      end
    end
    for (int t = IPC_NTRAP - 1; t >= 0; t--) begin
      if (trap_flag_r[t]) begin
        best_lvl  = IPC_LVL_TRAP_LO + 4'(t);
        best_vec  = IPC_VEC_TRAP0 + 7'(t);
        best_trap = 1'b1;
      end
    end
  end

  // Gating: CPU level, nesting, timed disable; traps bypass all.
  // A user request must beat the current CPU level strictly. Level 7
  // therefore shuts out every user source. With nesting disabled, nothing
  // user-level passes while any handler is stacked. The timed disable
  // holds back levels 1 to 6 only, so level 7 sources stay live.
  logic timed_irq_disable_act;
  logic in_isr;
  logic user_ok;
  assign timed_irq_disable_act = (timed_irq_disable_cnt_r != 16'h0000);
  assign in_isr   = (sp_r != '0);
  always_comb begin
    user_ok = (best_lvl > lvl_r);
    if (nest_dis_r && in_isr) begin
      user_ok = 1'b0;
    end
    if (timed_irq_disable_act && best_lvl < IPC_LVL_MAX_USER) begin
      user_ok = 1'b0;
    end
  end
  assign cpu_irq_o       = best_trap || (best_lvl != 4'h0 && user_ok);
  assign cpu_vector_o    = best_vec;
  assign cpu_level_now_o = lvl_r;

  // Pending flags: request sets, write-one clears, set wins. A flag that
  // stays set through return makes the source win again at once.
  // Set wins so that a request arriving in the clearing cycle is not lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= '0;
    end else begin
      pend_r <= (wr_en && adr_i == IPC_OFS_PEND) ?
                ((pend_r & ~dat_i[IPC_NSRC-1:0]) | src_req_i) :
                (pend_r | src_req_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= '0;
    end else if (wr_en && adr_i == IPC_OFS_ENABLE) begin
      en_r <= dat_i[IPC_NSRC-1:0];
    end
  end

  // Control register one: nesting disable and trap flags.
  // Trap flags clear by writing zero to them. A flag left set keeps its
  // trap on offer, so the trap handler is entered again after return.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nest_dis_r  <= 1'b0;
      trap_flag_r <= '0;
    end else begin
      if (wr_en && adr_i == IPC_OFS_CTRL1) begin
        nest_dis_r  <= dat_i[IPC_NEST_DIS_BIT];
        trap_flag_r <= (trap_flag_r & dat_i[IPC_NTRAP-1:0]) | trap_req_i;
      end else begin
        trap_flag_r <= trap_flag_r | trap_req_i;
      end
    end
  end

  // CPU level and save stack; take pushes, return pops.
  // Take has priority over return. The core model never does both in one
  // cycle. A software write to the status byte is the lowest priority, so
  // a take in flight is never overwritten. The stack has no reset, because
  // its entries are read only after they have been pushed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_r             <= 4'h0;
      status_low_byte_r <= 8'h00;
      sp_r              <= '0;
    end else if (take_i && cpu_irq_o && sp_r != ($clog2(DEPTH+1))'(DEPTH)) begin
      stk_lvl_r[sp_r[$clog2(DEPTH)-1:0]] <= lvl_r;
      stk_sr_r[sp_r[$clog2(DEPTH)-1:0]]  <= status_low_byte_r;
      lvl_r <= best_lvl;
      status_low_byte_r <= {best_lvl[2:0], status_low_byte_r[4:0]};
      sp_r  <= sp_r + 1'b1;
    end else if (return_from_irq_i && in_isr) begin
      lvl_r             <= stk_lvl_r[sp_r[$clog2(DEPTH)-1:0] - 1'b1];
      status_low_byte_r <= stk_sr_r[sp_r[$clog2(DEPTH)-1:0] - 1'b1];
      sp_r              <= sp_r - 1'b1;
    end else if (wr_en && adr_i == IPC_OFS_CPUSTAT) begin
      status_low_byte_r <= dat_i[7:0];
      lvl_r <= {1'b0, dat_i[7:5]};
    end
  end

  // Timed disable counter; a new command restarts the period.
  // Restarting rather than adding keeps the worst-case hold-off bounded to
  // one period after the last command.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timed_irq_disable_cnt_r <= 16'h0000;
    end else if (timed_irq_disable_i) begin
      timed_irq_disable_cnt_r <= 16'(TIMED_IRQ_DISABLE_CYCLES);
    end else if (timed_irq_disable_act) begin
      timed_irq_disable_cnt_r <= timed_irq_disable_cnt_r - 16'h0001;
    end
  end

  // Event status, write one to clear, set wins; masked onto irq_o.
  // These events serve a debug or supervisor view and are independent of
  // the core request path above.
  logic [IPC_NEV-1:0] ev_set;
  assign ev_set = {timed_irq_disable_i, |trap_req_i, take_i && cpu_irq_o};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_stat_r <= '0;
      ev_mask_r <= '0;
    end else begin
      if (wr_en && adr_i == IPC_OFS_IRQ_STAT) begin
        ev_stat_r <= (ev_stat_r & ~dat_i[IPC_NEV-1:0]) | ev_set;
      end else begin
        ev_stat_r <= ev_stat_r | ev_set;
      end
      if (wr_en && adr_i == IPC_OFS_IRQ_MASK) begin
        ev_mask_r <= dat_i[IPC_NEV-1:0];
      end
    end
  end
  assign irq_o = |(ev_stat_r & ev_mask_r);

  // Read data, registered alongside ack; unmapped reads give zero.
  // The word is cleared first, and only implemented fields are laid over
  // it. Every unused bit therefore reads as zero whatever was written.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      dat_o <= 32'h0000_0000;
      for (int s = 0; s < IPC_NSRC; s++) begin
        if (adr_i == src_ofs(s)) begin
          dat_o[src_pos(s) +: 3] <= prio_r[s];
        end
      end
      case (adr_i)
        IPC_OFS_VECSTAT: dat_o[11:0] <= {lvl_r, 1'b0, best_vec};
        IPC_OFS_CTRL1:   dat_o[15:0] <= {nest_dis_r, 11'h000, trap_flag_r};
        IPC_OFS_PEND:    dat_o[IPC_NSRC-1:0] <= pend_r;
        IPC_OFS_ENABLE:  dat_o[IPC_NSRC-1:0] <= en_r;
        IPC_OFS_CPUSTAT: dat_o[7:0] <= status_low_byte_r;
        IPC_OFS_IRQ_STAT: dat_o[IPC_NEV-1:0] <= ev_stat_r;
        IPC_OFS_IRQ_MASK: dat_o[IPC_NEV-1:0] <= ev_mask_r;
        default: ;
      endcase
    end
  end

endmodule : ipc_core

// *** inc/ipc_pkg.sv ***
// Package for the interrupt priority control block: register map,
// field positions, reset values and timing counts.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
package ipc_pkg;
  // Register byte offsets
  localparam logic [7:0] IPC_OFS_PRIO9    = 8'h00;
  localparam logic [7:0] IPC_OFS_PRIO11   = 8'h04;
  localparam logic [7:0] IPC_OFS_PRIO15   = 8'h08;
  localparam logic [7:0] IPC_OFS_PRIO16   = 8'h0c;
  localparam logic [7:0] IPC_OFS_PRIO17   = 8'h10;
  localparam logic [7:0] IPC_OFS_VECSTAT  = 8'h14;
  localparam logic [7:0] IPC_OFS_CTRL1    = 8'h18;
  localparam logic [7:0] IPC_OFS_PEND     = 8'h1c;
  localparam logic [7:0] IPC_OFS_ENABLE   = 8'h20;
  localparam logic [7:0] IPC_OFS_CPUSTAT  = 8'h24;
  localparam logic [7:0] IPC_OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] IPC_OFS_IRQ_MASK = 8'h2c;

  // Source indices (11 user sources)
  localparam int IPC_NSRC      = 11;
  localparam int IPC_SRC_X3    = 0;
  localparam int IPC_SRC_X4    = 1;
  localparam int IPC_SRC_PP    = 2;
  localparam int IPC_SRC_X5    = 3;
  localparam int IPC_SRC_CAL   = 4;
  localparam int IPC_SRC_S1E   = 5;
  localparam int IPC_SRC_S2E   = 6;
  localparam int IPC_SRC_CRC   = 7;
  localparam int IPC_SRC_X6    = 8;
  localparam int IPC_SRC_X7    = 9;
  localparam int IPC_SRC_CANTX = 10;

  // Field low positions (3-bit fields), per source
  localparam int IPC_POS_LO  = 0;
  localparam int IPC_POS_MID = 4;
  localparam int IPC_POS_HI  = 8;
  localparam int IPC_POS_TOP = 12;

  localparam logic [2:0] IPC_PRIO_RST = 3'h4;   // Level 4 after reset
  localparam logic [2:0] IPC_PRIO_OFF = 3'h0;
  localparam logic [3:0] IPC_LVL_MAX_USER = 4'h7;
  localparam logic [3:0] IPC_LVL_TRAP_LO  = 4'h8;

  // Control register one fields
  localparam int IPC_NEST_DIS_BIT = 15;
  localparam int IPC_NTRAP        = 4;

  // Vector numbering: user source n maps to vector base + n
  localparam logic [6:0] IPC_VEC_BASE  = 7'h08;
  localparam logic [6:0] IPC_VEC_TRAP0 = 7'h00;

  // Timed disable length
  localparam int IPC_TIMED_IRQ_DISABLE_CYCLES = 16;

  // Interrupt status bits
  localparam int IPC_EV_TAKE = 0;
  localparam int IPC_EV_TRAP = 1;
  localparam int IPC_EV_TIMED_IRQ_DISABLE = 2;
  localparam int IPC_NEV     = 3;
endpackage : ipc_pkg

// *** sim/ipc_core_monitor.sv ***
// Checker for ipc_core: bus answer, level masking, traps, returns.
// Assumes binding onto ipc_core; one clock, sync high reset.
`timescale 1ns/100ps
module ipc_core_monitor
  import ipc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic [3:0] trap_req_i,
  input wire logic       take_i,
  input wire logic       return_from_irq_i,
  input wire logic       cpu_irq_o,
  input wire logic [6:0] cpu_vector_o,
  input wire logic [3:0] cpu_level_now_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // One ack per request, a cycle later, never unasked
  a_ack_single:
    assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_answer:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_ack_unasked:
    assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
  // Level 7 leaves only trap vectors on offer
  a_user_masked:
    assert property (cpu_level_now_o >= 4'h7 && cpu_irq_o |-> cpu_vector_o < 7'h04)
    else $error("user irq at level 7");
  a_trap_passes:
    assert property (trap_req_i != 4'h0 && cpu_level_now_o < 4'h8 && !take_i |=> cpu_irq_o)
    else $error("trap not offered");
  a_vector_range:
    assert property (cpu_irq_o |-> cpu_vector_o < 7'h04
                     || (cpu_vector_o >= IPC_VEC_BASE && cpu_vector_o < 7'h13))
    else $error("bad vector");
  // A user take raises the level; a trap goes to 8 plus its index
  a_take_raises:
    assert property (take_i && cpu_irq_o && cpu_vector_o >= 7'h08
                     |=> cpu_level_now_o > $past(cpu_level_now_o))
    else $error("level not raised");
  a_trap_level:
    assert property (take_i && cpu_irq_o && cpu_vector_o < 7'h04
                     |=> cpu_level_now_o == {2'b10, $past(cpu_vector_o[1:0])})
    else $error("trap level wrong");
  a_ret_restore:
    assert property (take_i && cpu_irq_o ##1 (return_from_irq_i && !take_i)
                     |=> cpu_level_now_o == $past(cpu_level_now_o, 2))
    else $error("level not restored");
endmodule : ipc_core_monitor

bind ipc_core ipc_core_monitor u_ipc_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .trap_req_i(trap_req_i), .take_i(take_i), .return_from_irq_i(return_from_irq_i),
  .cpu_irq_o(cpu_irq_o), .cpu_vector_o(cpu_vector_o), .cpu_level_now_o(cpu_level_now_o));

// *** sim/ipc_core_model.sv ***
// Core model: takes an offered interrupt, serves it, returns.
// Assumes one handler at a time; it never clears the flag itself.
`timescale 1ns/100ps
module ipc_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic [3:0] svc_i,
  input  wire logic       cpu_irq_i,
  input  wire logic [6:0] cpu_vector_i,
  output logic            take_o,
  output logic            ret_o,
  output logic [6:0]      vec_o,
  output logic [7:0]      takes_o,
  output logic            busy_o
);
  logic [3:0] cnt_r;
  // Service for svc_i cycles; no take in the return cycle
  always_ff @(posedge clk_i) begin
    take_o <= 1'b0;
    ret_o  <= 1'b0;
    if (rst_i) begin
      cnt_r   <= 4'h0;
      busy_o  <= 1'b0;
      takes_o <= 8'h0;
      vec_o   <= 7'h0;
    end else if (busy_o) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1) begin
        ret_o  <= 1'b1;
        busy_o <= 1'b0;
      end
    end else if (en_i && cpu_irq_i && !ret_o) begin
      take_o  <= 1'b1;
      busy_o  <= 1'b1;
      cnt_r   <= svc_i;
      vec_o   <= cpu_vector_i;
      takes_o <= takes_o + 8'h1;
    end
  end
endmodule : ipc_core_model

// *** sim/ipc_core_bench.sv ***
// Bench for ipc_core: registers, priorities, traps, timed disable,
// service by the core model and the event interrupt.
`timescale 1ns/100ps
module ipc_core_bench
  import ipc_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, en = 0, tdis = 0;
  logic [7:0]  adr = 0;
  logic [3:0]  trap = 0, svc = 1;
  logic [10:0] src = 0;
  logic [31:0] wdat = 0, rdat, q, d, seed = 32'hcf57;
  logic        ack, irq, cpu_irq, take, ret, busy;
  logic [6:0]  vec, lvec;
  logic [3:0]  lvl;
  logic [7:0]  takes;
  logic [31:0] rstv [5] = '{32'h4, 32'h440, 32'h440, 32'h4440, 32'h444};
  logic [31:0] msk [5]  = '{32'h7, 32'h770, 32'h770, 32'h7770, 32'h777};
  int          num_errors = 0, tests_run = 0, cycles = 0;

  ipc_core #(.TIMED_IRQ_DISABLE_CYCLES(8)) i_ipc_core (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .src_req_i(src),
    .trap_req_i(trap), .take_i(take), .return_from_irq_i(ret),
    .timed_irq_disable_i(tdis), .cpu_irq_o(cpu_irq), .cpu_vector_o(vec),
    .cpu_level_now_o(lvl), .irq_o(irq));
  ipc_core_model i_ipc_core_model (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(en), .svc_i(svc), .cpu_irq_i(cpu_irq),
    .cpu_vector_i(vec), .take_o(take), .ret_o(ret), .vec_o(lvec), .takes_o(takes),
    .busy_o(busy));

  // Clock and a cycle ceiling against hangs
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      print_verdict();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dv;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic pulse(input logic [10:0] s, input logic [3:0] t, input logic dis);
    src <= s;
    trap <= t;
    tdis <= dis;
    @(posedge clk_i);
    src <= 11'h0;
    trap <= 4'h0;
    tdis <= 1'b0;
    @(posedge clk_i);
  endtask : pulse
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, then random writes masked to the fields
    for (int i = 0; i < 5; i++) begin
      wb(0, 8'(4 * i), 0);
      chk(q, rstv[i]);
      d = xs();
      wb(1, 8'(4 * i), d);
      wb(0, 8'(4 * i), 0);
      chk(q, d & msk[i]);
    end
    wb(1, IPC_OFS_PRIO9, 32'hffffffff);
    wb(0, IPC_OFS_PRIO9, 0);
    chk(q, 32'h7);
    wb(1, 8'h3c, 32'hffffffff);
    wb(0, 8'h3c, 0);
    chk(q, 0);
    wb(1, IPC_OFS_VECSTAT, 32'hffffffff);
    wb(0, IPC_OFS_VECSTAT, 0);
    chk(q & 32'hfffff080, 0);
    $display("test registers finished");
    // Setup order: priority, clear flag, enable
    wb(1, IPC_OFS_PRIO9, 0);
    wb(1, IPC_OFS_PEND, 32'h7ff);
    wb(1, IPC_OFS_ENABLE, 32'h5);
    pulse(11'h1, 4'h0, 1'b0);
    chk(cpu_irq, 0);
    wb(1, IPC_OFS_PRIO9, 32'h3);
    wb(0, IPC_OFS_VECSTAT, 0);
    chk({cpu_irq, q[6:0]}, {1'b1, 7'h08});
    wb(1, IPC_OFS_PRIO11, 32'h50);
    pulse(11'h4, 4'h0, 1'b0);
    chk(vec, 7'h0a);
    $display("test priorities finished");
    // Level 7 masks users but not traps
    wb(1, IPC_OFS_CPUSTAT, 32'he0);
    chk({cpu_irq, lvl}, {1'b0, 4'h7});
    pulse(11'h0, 4'h2, 1'b0);
    chk({cpu_irq, vec}, {1'b1, 7'h01});
    wb(1, IPC_OFS_CTRL1, 0);
    wb(1, IPC_OFS_CPUSTAT, 0);
    chk({cpu_irq, vec}, {1'b1, 7'h0a});
    $display("test masking finished");
    // Timed disable holds back level 5, lets level 7 through
    pulse(11'h0, 4'h0, 1'b1);
    chk(cpu_irq, 0);
    wb(1, IPC_OFS_PRIO9, 32'h7);
    chk({cpu_irq, vec}, {1'b1, 7'h08});
    repeat (10) @(posedge clk_i);
    $display("test timed disable finished");
    // Prompt then slow handlers that leave the flag set
    en <= 1'b1;
    while (takes < 8'h2) @(posedge clk_i);
    d = xs();
    svc <= {1'b0, d[2:0]} | 4'h2;
    while (takes < 8'h4) @(posedge clk_i);
    @(posedge clk_i);
    chk({lvec, lvl}, {7'h08, 4'h7});
    wb(0, IPC_OFS_IRQ_STAT, 0);
    chk({irq, q[0]}, 2'b01);
    wb(1, IPC_OFS_IRQ_MASK, 32'h1);
    chk(irq, 1);
    en <= 1'b0;
    wb(1, IPC_OFS_PEND, 32'h7ff);
    while (busy) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    chk({cpu_irq, lvl}, 0);
    wb(1, IPC_OFS_IRQ_STAT, 32'h7);
    chk(irq, 0);
    $display("test service finished");
    print_verdict();
  end
endmodule : ipc_core_bench
